// file: inc/viu_pkg.sv
// Constants for the vectored interrupt unit
package viu_pkg;
  localparam int unsigned NUM_CHANNELS = 32;
  localparam logic [23:0] ADDR_VECTOR = 24'hFFFE00;
  localparam logic [23:0] ADDR_NMI_FLAGS = 24'hFFFE02;
  localparam logic [23:0] ADDR_NMI_CTRL = 24'hFFFE04;
  localparam logic [23:0] ADDR_PEND_LOW = 24'hFFFE0A;
  localparam logic [23:0] ADDR_PEND_HIGH = 24'hFFFE0C;
  localparam logic [23:0] ADDR_ENABLE_LOW = 24'hFFFE0E;
  localparam logic [23:0] ADDR_ENABLE_HIGH = 24'hFFFE10;
  localparam logic [23:0] ADDR_EDGE_CLEAR_LOW = 24'hFFFE12;
  localparam logic [23:0] ADDR_EDGE_CLEAR_HIGH = 24'hFFFE14;
  localparam logic [7:0] VECTOR_BASE = 8'h10;
  localparam logic [7:0] VECTOR_RESET = 8'h10;
  localparam logic [31:0] EDGE_CHANNELS = 32'h80000000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam int unsigned NMI_EXT_BIT = 0;
  localparam int unsigned NMI_PROT_BIT = 1;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_PIN_BIT = 1;
  localparam int unsigned CTRL_LOCK_BIT = 2;
endpackage

// file: src/viu_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module viu_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("viu_sync width must be at least one");
  end

  // Reset level must match the input's idle level, or an edge detector sees a false edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: src/viu_prio.sv
// Fixed-priority encoder, highest index wins
`timescale 1ns/1ps
`default_nettype none
module viu_prio #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic [WIDTH-1:0] req,
  output logic [$clog2(WIDTH)-1:0] index,
  output logic any
);
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("viu_prio width out of range");
  end

  always_comb begin
    index = '0;
    any = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      if (req[i]) begin
        index = ($clog2(WIDTH))'(i);
        any = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/viu_top.sv
// Vectored interrupt unit: maskable channels and non-maskable sources
`timescale 1ns/1ps
`default_nettype none
module viu_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  input wire logic [31:1] irq_src,
  input wire logic ext_nmi_pin,
  input wire logic flash_prot_write,
  output logic core_irq,
  output logic core_nmi
);
  localparam int unsigned NCH = viu_pkg::NUM_CHANNELS;
  // Both channel words of the register map must be full
  if (NCH != 32) begin : g_bad_count
    $error("viu_top needs 32 channel slots");
  end

  // Sources arrive asynchronously through the wake-up path
  logic [NCH-1:0] src_sync;
  logic [NCH-2:0] src_sync_raw;
  logic pin_sync;

  viu_sync #(.WIDTH(NCH-1)) u_src_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(irq_src),
    .sync_out(src_sync_raw)
  );

  // Pin idles high, so its synchroniser resets high and no false fall follows reset
  viu_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(ext_nmi_pin),
    .sync_out(pin_sync)
  );

  assign src_sync = {src_sync_raw, 1'b0};

  // Register decode
  function automatic logic addr_is(input logic [23:0] addr, input logic [23:0] target);
    return addr == target;
  endfunction

  wire rd_nmi_flags = bus_rd && addr_is(bus_addr, viu_pkg::ADDR_NMI_FLAGS);
  wire wr_nmi_ctrl = bus_wr && addr_is(bus_addr, viu_pkg::ADDR_NMI_CTRL);
  wire wr_en_low = bus_wr && addr_is(bus_addr, viu_pkg::ADDR_ENABLE_LOW);
  wire wr_en_high = bus_wr && addr_is(bus_addr, viu_pkg::ADDR_ENABLE_HIGH);
  wire wr_clr_low = bus_wr && addr_is(bus_addr, viu_pkg::ADDR_EDGE_CLEAR_LOW);
  wire wr_clr_high = bus_wr && addr_is(bus_addr, viu_pkg::ADDR_EDGE_CLEAR_HIGH);

  // Maskable channels
  logic [NCH-1:0] enable_reg;
  logic [NCH-1:0] edge_latch_reg;
  logic [NCH-1:0] src_prev_reg;
  logic [NCH-1:0] pending;
  logic [NCH-1:0] edge_clear;
  logic [NCH-1:0] edge_rise;
  logic [NCH-1:0] enable_next;

  assign edge_clear = {wr_clr_high ? bus_wdata : 16'h0000,
                       wr_clr_low ? bus_wdata : 16'h0000};
  assign edge_rise = src_sync & ~src_prev_reg;
  assign enable_next = {wr_en_high ? bus_wdata : enable_reg[31:16],
                        wr_en_low ? bus_wdata : enable_reg[15:0]};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      if (viu_pkg::EDGE_CHANNELS[g]) begin : g_edge
        assign pending[g] = edge_latch_reg[g];
      end else begin : g_level
        assign pending[g] = src_sync[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= {viu_pkg::ENABLE_RESET, viu_pkg::ENABLE_RESET};
      edge_latch_reg <= '0;
      src_prev_reg <= '0;
    end else begin
      enable_reg <= enable_next;
      src_prev_reg <= src_sync;
      // New edge wins over a clear in the same cycle
      edge_latch_reg <= (edge_latch_reg & ~edge_clear) | (edge_rise & viu_pkg::EDGE_CHANNELS);
    end
  end

  // Priority and vector
  logic [NCH-1:0] active;
  logic [4:0] best_index;
  logic best_any;
  logic [7:0] vector_reg;
  logic [7:0] vector_next;

  assign active = pending & enable_reg & ~32'h00000001;

  viu_prio #(.WIDTH(NCH)) u_prio (
    .req(active),
    .index(best_index),
    .any(best_any)
  );

  // A withdrawn request falls back to the channel-zero code
  assign vector_next = best_any ? (viu_pkg::VECTOR_BASE + {3'b000, best_index}) : viu_pkg::VECTOR_BASE;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vector_reg <= viu_pkg::VECTOR_RESET;
    end else begin
      vector_reg <= vector_next;
    end
  end

  assign core_irq = best_any;

  // Non-maskable sources
  logic pin_prev_reg;
  logic nmi_en_reg;
  logic nmi_lock_enable_reg;
  logic [1:0] nmi_flags_reg;
  wire ext_path_on = nmi_lock_enable_reg || nmi_en_reg;
  wire pin_fall = pin_prev_reg && !pin_sync;
  wire ext_event = pin_fall && ext_path_on;
  wire en_write_val = bus_wdata[viu_pkg::CTRL_EN_BIT];
  // Software may only set the one-shot bit while the external flag is clear
  wire en_set_ok = !nmi_flags_reg[viu_pkg::NMI_EXT_BIT];
  logic nmi_en_next;
  logic [1:0] nmi_flags_next;

  always_comb begin
    nmi_en_next = nmi_en_reg;
    if (wr_nmi_ctrl) begin
      if (!en_write_val || en_set_ok) begin
        nmi_en_next = en_write_val;
      end
    end
    if (ext_event) begin
      nmi_en_next = 1'b0;
    end
  end

  always_comb begin
    nmi_flags_next = rd_nmi_flags ? 2'b00 : nmi_flags_reg;
    if (ext_event) begin
      nmi_flags_next[viu_pkg::NMI_EXT_BIT] = 1'b1;
    end
    if (flash_prot_write) begin
      nmi_flags_next[viu_pkg::NMI_PROT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b1;
      nmi_en_reg <= 1'b0;
      nmi_lock_enable_reg <= 1'b0;
      nmi_flags_reg <= 2'b00;
    end else begin
      pin_prev_reg <= pin_sync;
      nmi_en_reg <= nmi_en_next;
      // Write-one-to-set, no software clear
      if (wr_nmi_ctrl && bus_wdata[viu_pkg::CTRL_LOCK_BIT]) begin
        nmi_lock_enable_reg <= 1'b1;
      end
      nmi_flags_reg <= nmi_flags_next;
    end
  end

  assign core_nmi = |nmi_flags_reg;

  // Read mux, combinational so the acknowledge read sees the vector
  always_comb begin
    bus_rdata = 16'h0000;
    if (bus_rd) begin
      case (bus_addr)
        viu_pkg::ADDR_VECTOR: bus_rdata = {8'h00, 2'b00, vector_reg[5:0]};
        viu_pkg::ADDR_NMI_FLAGS: bus_rdata = {14'h0000, nmi_flags_reg};
        viu_pkg::ADDR_NMI_CTRL: bus_rdata = {13'h0000, nmi_lock_enable_reg, pin_sync, nmi_en_reg};
        viu_pkg::ADDR_PEND_LOW: bus_rdata = pending[15:0];
        viu_pkg::ADDR_PEND_HIGH: bus_rdata = pending[31:16];
        viu_pkg::ADDR_ENABLE_LOW: bus_rdata = enable_reg[15:0];
        viu_pkg::ADDR_ENABLE_HIGH: bus_rdata = enable_reg[31:16];
        default: bus_rdata = 16'h0000;
      endcase
    end
  end

  a_nmi_out: assert property (@(posedge core_clk) disable iff (rst)
    core_nmi == (nmi_flags_reg != 2'b00)) else $error("nmi output mismatch");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (rst)
    (rd_nmi_flags && !ext_event && !flash_prot_write) |=> (nmi_flags_reg == 2'b00)) else $error("flags not cleared");
  a_prot_nmi: assert property (@(posedge core_clk) disable iff (rst)
    flash_prot_write |=> core_nmi) else $error("protected write lost");
  a_oneshot_drop: assert property (@(posedge core_clk) disable iff (rst)
    (ext_event && !nmi_lock_enable_reg) |=> !nmi_en_reg) else $error("one-shot not cleared");
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (rst)
    nmi_lock_enable_reg |=> nmi_lock_enable_reg) else $error("lock cleared");
  a_vector_range: assert property (@(posedge core_clk) disable iff (rst)
    (vector_reg >= 8'h10) && (vector_reg <= 8'h2F)) else $error("vector out of range");
  a_vector_idle: assert property (@(posedge core_clk) disable iff (rst)
    !best_any |=> (vector_reg == 8'h10)) else $error("idle vector wrong");
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    core_irq == ((pending & enable_reg) != 32'h00000000)) else $error("irq mismatch");
  a_edge_hold: assert property (@(posedge core_clk) disable iff (rst)
    (edge_latch_reg[31] && !edge_clear[31]) |=> edge_latch_reg[31]) else $error("edge latch lost");
  a_ext_fall: assert property (@(posedge core_clk) disable iff (rst)
    (pin_fall && ext_path_on) |=> nmi_flags_reg[0]) else $error("pin edge missed");

  // Maskable path
  a_chan_zero: assert property (@(posedge core_clk) disable iff (rst)
    !active[0]) else $error("channel zero active");
  a_level_follow: assert property (@(posedge core_clk) disable iff (rst)
    pending[30:1] == src_sync[30:1]) else $error("level status not following source");
  a_edge_set: assert property (@(posedge core_clk) disable iff (rst)
    edge_rise[31] |=> edge_latch_reg[31]) else $error("top channel edge not latched");
  a_edge_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (!edge_rise[31] && !edge_latch_reg[31]) |=> !edge_latch_reg[31]) else $error("top channel set without edge");
  a_edge_clear: assert property (@(posedge core_clk) disable iff (rst)
    (edge_clear[31] && !edge_rise[31]) |=> !edge_latch_reg[31]) else $error("edge latch not cleared");
  a_enable_low: assert property (@(posedge core_clk) disable iff (rst)
    wr_en_low |=> (enable_reg[15:0] == $past(bus_wdata))) else $error("low enable write lost");
  a_enable_high: assert property (@(posedge core_clk) disable iff (rst)
    wr_en_high |=> (enable_reg[31:16] == $past(bus_wdata))) else $error("high enable write lost");
  a_enable_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!wr_en_low && !wr_en_high) |=> (enable_reg == $past(enable_reg))) else $error("enable changed unasked");
  a_prio_top: assert property (@(posedge core_clk) disable iff (rst)
    best_any |-> ((active >> best_index) == 32'h00000001)) else $error("lower channel won");
  a_irq_chan: assert property (@(posedge core_clk) disable iff (rst)
    (|(src_sync & enable_reg & ~viu_pkg::EDGE_CHANNELS & ~32'h00000001)) |-> core_irq) else $error("level request lost");
  a_irq_idle: assert property (@(posedge core_clk) disable iff (rst)
    (active == 32'h00000000) |-> !core_irq) else $error("request without active channel");
  a_vector_map: assert property (@(posedge core_clk) disable iff (rst)
    best_any |=> (vector_reg == (viu_pkg::VECTOR_BASE + {3'b000, $past(best_index)}))) else $error("vector code wrong");
  a_vector_top: assert property (@(posedge core_clk) disable iff (rst)
    vector_reg[7:6] == 2'b00) else $error("vector upper bits set");
  a_ack_byte: assert property (@(posedge core_clk) disable iff (rst)
    (bus_rd && addr_is(bus_addr, viu_pkg::ADDR_VECTOR)) |-> (bus_rdata[7:0] == vector_reg)) else $error("ack byte wrong");
  a_status_high: assert property (@(posedge core_clk) disable iff (rst)
    (bus_rd && addr_is(bus_addr, viu_pkg::ADDR_PEND_HIGH)) |-> (bus_rdata == pending[31:16])) else $error("status word wrong");

  // Non-maskable path
  a_en_refused: assert property (@(posedge core_clk) disable iff (rst)
    (wr_nmi_ctrl && en_write_val && nmi_flags_reg[viu_pkg::NMI_EXT_BIT] && !nmi_en_reg) |=> !nmi_en_reg)
    else $error("one-shot set while flag pending");
  a_en_clear: assert property (@(posedge core_clk) disable iff (rst)
    (wr_nmi_ctrl && !en_write_val) |=> !nmi_en_reg) else $error("one-shot not cleared by write");
  a_lock_set: assert property (@(posedge core_clk) disable iff (rst)
    (wr_nmi_ctrl && bus_wdata[viu_pkg::CTRL_LOCK_BIT]) |=> nmi_lock_enable_reg) else $error("lock not set");
  a_lock_path: assert property (@(posedge core_clk) disable iff (rst)
    (nmi_lock_enable_reg && pin_fall) |=> nmi_flags_reg[viu_pkg::NMI_EXT_BIT]) else $error("locked path missed edge");
  a_ext_blocked: assert property (@(posedge core_clk) disable iff (rst)
    (!ext_path_on && !nmi_flags_reg[viu_pkg::NMI_EXT_BIT]) |=> !nmi_flags_reg[viu_pkg::NMI_EXT_BIT])
    else $error("external flag set while path off");
  a_prot_flag: assert property (@(posedge core_clk) disable iff (rst)
    flash_prot_write |=> nmi_flags_reg[viu_pkg::NMI_PROT_BIT]) else $error("protected flag not set");
  a_prot_hold: assert property (@(posedge core_clk) disable iff (rst)
    (nmi_flags_reg[viu_pkg::NMI_PROT_BIT] && !rd_nmi_flags) |=> nmi_flags_reg[viu_pkg::NMI_PROT_BIT])
    else $error("protected flag dropped unread");
  a_ext_hold: assert property (@(posedge core_clk) disable iff (rst)
    (nmi_flags_reg[viu_pkg::NMI_EXT_BIT] && !rd_nmi_flags) |=> nmi_flags_reg[viu_pkg::NMI_EXT_BIT])
    else $error("external flag dropped unread");
endmodule
`default_nettype wire

// file: tb/viu_core_model.sv
// Processor core model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
  input wire logic core_clk,
  input wire logic [15:0] bus_rdata,
  output logic [23:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic [15:0] bus_wdata
);
  initial begin
    bus_addr = 24'h000000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 16'h0000;
  end
  // Released address and data lines get inverted, strobes drop low, no pull on this bus
  task automatic release_bus();
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
  // Clears may be issued while a core interrupt is pending
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge core_clk);
    #1;
    release_bus();
  endtask
  // Acknowledge and flag reads: one cycle, data taken at the edge
  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge core_clk);
    d = bus_rdata;
    #1;
    release_bus();
  endtask
endmodule
`default_nettype wire

// file: tb/vectored_interrupt_unit_test.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_unit_test;
  logic core_clk, rst, bus_rd, bus_wr, ext_nmi_pin, flash_prot_write, core_irq, core_nmi;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [31:1] irq_src;
  logic [31:0] src, en;
  logic [7:0] ev;
  int err_total = 0;
  int n_checks = 0;
  viu_top i_viu_top (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .irq_src(irq_src),
    .ext_nmi_pin(ext_nmi_pin), .flash_prot_write(flash_prot_write), .core_irq(core_irq),
    .core_nmi(core_nmi));
  viu_core_model i_viu_core_model (.core_clk(core_clk), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Run needs a few hundred cycles
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [23:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    i_viu_core_model.rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
  endtask
  task automatic fall();
    ext_nmi_pin = 1'b0;
    tick(6);
    ext_nmi_pin = 1'b1;
    tick(6);
  endtask
  task automatic prot_pulse();
    flash_prot_write = 1'b1;
    tick(1);
    flash_prot_write = 1'b0;
    tick(1);
  endtask
  initial begin
    rst = 1'b1;
    irq_src = '0;
    ext_nmi_pin = 1'b1; // Pin set up before any enable
    flash_prot_write = 1'b0;
    void'($urandom(32'h84f0));
    do_reset();
    rchk(viu_pkg::ADDR_VECTOR, 16'h0010, "vector_reset");
    rchk(viu_pkg::ADDR_NMI_CTRL, 16'h0002, "nmi_ctrl_reset");
    rchk(viu_pkg::ADDR_ENABLE_LOW, 16'h0000, "enable_reset");
    // Random level channels, last pass withdraws every request
    for (int i = 0; i < 9; i++) begin
      en = $urandom;
      src = (i == 8) ? 32'h0 : ($urandom & 32'h7FFFFFFE);
      i_viu_core_model.wr(viu_pkg::ADDR_ENABLE_LOW, en[15:0]);
      i_viu_core_model.wr(viu_pkg::ADDR_ENABLE_HIGH, en[31:16]);
      irq_src = src[31:1];
      tick(4);
      ev = viu_pkg::VECTOR_BASE;
      for (int c = 1; c < 32; c++) if (src[c] && en[c]) ev = 8'h10 + 8'(c);
      rchk(viu_pkg::ADDR_PEND_LOW, src[15:0], "pending_low");
      rchk(viu_pkg::ADDR_PEND_HIGH, src[31:16], "pending_high");
      rchk(viu_pkg::ADDR_VECTOR, {8'h00, ev}, "vector");
      chk("core_irq", {15'h0, core_irq}, {15'h0, |(src & en)});
    end
    irq_src = '0;
    i_viu_core_model.wr(viu_pkg::ADDR_ENABLE_HIGH, 16'h8000);
    irq_src[31] = 1'b1;
    tick(1);
    irq_src[31] = 1'b0;
    tick(4);
    rchk(viu_pkg::ADDR_PEND_HIGH, 16'h8000, "edge_latch");
    rchk(viu_pkg::ADDR_VECTOR, 16'h002F, "top_vector");
    i_viu_core_model.wr(viu_pkg::ADDR_EDGE_CLEAR_HIGH, 16'h7FFF);
    rchk(viu_pkg::ADDR_PEND_HIGH, 16'h8000, "edge_keep");
    i_viu_core_model.wr(viu_pkg::ADDR_EDGE_CLEAR_HIGH, 16'h8000);
    tick(2);
    rchk(viu_pkg::ADDR_PEND_HIGH, 16'h0000, "edge_clear");
    rchk(24'hFFFE08, 16'h0000, "unmapped");
    fall();
    chk("nmi_off", {15'h0, core_nmi}, 16'h0000);
    i_viu_core_model.wr(viu_pkg::ADDR_NMI_CTRL, 16'h0001);
    fall();
    chk("nmi_pin", {15'h0, core_nmi}, 16'h0001);
    i_viu_core_model.wr(viu_pkg::ADDR_NMI_CTRL, 16'h0001);
    rchk(viu_pkg::ADDR_NMI_CTRL, 16'h0002, "one_shot");
    rchk(viu_pkg::ADDR_NMI_FLAGS, 16'h0001, "flags_ext");
    rchk(viu_pkg::ADDR_NMI_FLAGS, 16'h0000, "flags_clr");
    prot_pulse();
    chk("nmi_prot", {15'h0, core_nmi}, 16'h0001);
    rchk(viu_pkg::ADDR_NMI_FLAGS, 16'h0002, "flags_prot");
    tick(1);
    chk("nmi_drop", {15'h0, core_nmi}, 16'h0000);
    i_viu_core_model.wr(viu_pkg::ADDR_NMI_CTRL, 16'h0004);
    i_viu_core_model.wr(viu_pkg::ADDR_NMI_CTRL, 16'h0000);
    rchk(viu_pkg::ADDR_NMI_CTRL, 16'h0006, "lock_kept");
    fall();
    rchk(viu_pkg::ADDR_NMI_FLAGS, 16'h0001, "lock_fall");
    prot_pulse();
    fall();
    rchk(viu_pkg::ADDR_NMI_FLAGS, 16'h0003, "flags_both");
    do_reset();
    rchk(viu_pkg::ADDR_NMI_CTRL, 16'h0002, "lock_reset");
    rchk(viu_pkg::ADDR_ENABLE_HIGH, 16'h0000, "enable_reset2");
    finish_test();
  end
endmodule
`default_nettype wire
